/* File: logic/ils_pkg.sv */
// Constants shared by the interrupt latch and enable sequencer.
package ils_pkg;

    // ==========================================================
    // Register addresses in the special-function space.
    localparam logic [7:0] ADDR_EN_UPPER  = 8'h2c;
    localparam logic [7:0] ADDR_LAT_UPPER = 8'h2e;
    localparam logic [7:0] ADDR_EN_LOW    = 8'h3a;
    localparam logic [7:0] ADDR_EN_HIGH   = 8'h3b;
    localparam logic [7:0] ADDR_LAT_LOW   = 8'h3c;
    localparam logic [7:0] ADDR_LAT_HIGH  = 8'h3d;

    // ==========================================================
    // Field positions and reset values.
    localparam int         IME_BIT        = 0;
    localparam int         PSW_IME_BIT    = 0;
    localparam int         LAT_LOW_FIRST  = 2;
    localparam int         EN_LOW_FIRST   = 4;
    localparam logic [7:0] REG_RESET      = 8'h00;

    // ==========================================================
    // Source numbering.
    localparam int         SRC_COUNT      = 24;
    localparam logic [4:0] SRC_SOFT       = 5'h01;
    localparam logic [4:0] SRC_FIRST_MASK = 5'h04;

    // ==========================================================
    // Acceptance timing in system clocks; ACC_MC counts machine cycles of MC_CLKS clocks.
    localparam int         MC_CLKS        = 4;
    localparam int         ACC_MC         = 8;
    localparam int         WORST_LAT_CLKS = 38;
    localparam logic [4:0] CNT_LAT_CLR    = 5'(1);
    localparam logic [4:0] CNT_PUSH_PSW   = 5'(2 * MC_CLKS);
    localparam logic [4:0] CNT_PUSH_PCH   = 5'(3 * MC_CLKS);
    localparam logic [4:0] CNT_PUSH_PCL   = 5'(4 * MC_CLKS);
    localparam logic [4:0] CNT_VEC_LOAD   = 5'(6 * MC_CLKS);
    localparam logic [4:0] CNT_LAST       = 5'(ACC_MC * MC_CLKS - 1);

    typedef enum logic {
        ILS_IDLE,
        ILS_RUN
    } ils_state_t;

endpackage

/* File: logic/ils_pick.sv */
// Fixed-priority selector over the eligible interrupt requests.
`timescale 1ns/10ps
module ils_pick
    import ils_pkg::*;
(
    // Eligible requests, one bit per source.
    input  wire logic [SRC_COUNT-1:0] req_i,
    // Winning source.
    output logic                      valid_o,
    output logic [4:0]                idx_o
);

    // ==========================================================
    // Lowest source number wins.
    always_comb begin
        valid_o = 1'b0;
        idx_o   = 5'h00;
        for (int i = SRC_COUNT - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                valid_o = 1'b1;
                idx_o   = 5'(i);
            end
        end
    end

endmodule

/* File: logic/ils_seq.sv */
// Interrupt latches, enable register and acceptance sequencer.
`timescale 1ns/10ps
module ils_seq
    import ils_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // Special-function register port.
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_rd_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  sfr_rdata_o,
    // Interrupt sources.
    input  wire logic [23:2] src_req_i,
    input  wire logic        swi_i,
    input  wire logic        undef_i,
    // CPU core side.
    input  wire logic        insn_end_i,
    input  wire logic        return_from_maskable_i,
    input  wire logic        return_from_nonmaskable_i,
    input  wire logic        stacked_ime_i,
    input  wire logic [7:0]  psw_i,
    input  wire logic [15:0] pc_i,
    output logic             acc_busy_o,
    output logic      [4:0]  acc_src_o,
    output logic             push_valid_o,
    output logic      [7:0]  push_data_o,
    output logic             sp_dec3_o,
    output logic             vector_load_o,
    output logic             exec_start_o,
    output logic             ime_o,
    output logic             nmi_service_o
);

    // ==========================================================
    // State.
    typedef struct packed {
        ils_state_t  state;
        logic [4:0]  cnt;
        logic [23:2] lat;
        logic [23:4] en;
        logic        ime;
        logic        saved_ime;
        logic [4:0]  src;
        logic        nmi_svc;
        logic [7:0]  rdata;
        logic        busy;
        logic        push_v;
        logic [7:0]  push_d;
        logic        sp_dec;
        logic        vec_ld;
        logic        exec;
    } ils_st_t;

    ils_st_t st_ff;
    ils_st_t nxt_st;

    logic [23:0] elig;
    logic        pk_valid;
    logic [4:0]  pk_idx;
    logic        take_nmi_insn;
    logic        take_any;
    logic [23:2] lat_clr;

    // ==========================================================
    // Helpers.
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target);
        wr_hit = (a == target);
    endfunction

    function automatic logic [7:0] rd_mux(input logic [7:0]  a,
                                          input logic [23:2] lat,
                                          input logic [23:4] en,
                                          input logic        ime);
        rd_mux = REG_RESET;
        unique case (a)
            ADDR_LAT_LOW:   rd_mux = {lat[7:2], 2'b00};
            ADDR_LAT_HIGH:  rd_mux = lat[15:8];
            ADDR_LAT_UPPER: rd_mux = lat[23:16];
            ADDR_EN_LOW:    rd_mux = {en[7:4], 3'b000, ime};
            ADDR_EN_HIGH:   rd_mux = en[15:8];
            ADDR_EN_UPPER:  rd_mux = en[23:16];
            default:        rd_mux = REG_RESET;
        endcase
    endfunction

    // ==========================================================
    // Request selection.
    // non-maskable bypass.
    always_comb begin
        elig        = 24'h000000;
        elig[23:4]  = st_ff.lat[23:4] & st_ff.en & {20{st_ff.ime}};
        elig[3:2]   = st_ff.lat[3:2];
    end

    ils_pick u_pick (
        .req_i   (elig),
        .valid_o (pk_valid),
        .idx_o   (pk_idx)
    );

    assign take_nmi_insn = insn_end_i && (swi_i || undef_i);
    assign take_any      = take_nmi_insn || (insn_end_i && pk_valid);

    // ==========================================================
    // Next state.
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.push_v = 1'b0;
        nxt_st.sp_dec = 1'b0;
        nxt_st.vec_ld = 1'b0;
        nxt_st.exec   = 1'b0;
        lat_clr       = '0;

        // Register reads.
        if (sfr_rd_i) begin
            nxt_st.rdata = rd_mux(sfr_addr_i, st_ff.lat, st_ff.en, st_ff.ime);
        end

        // Register writes.
        if (sfr_wr_i) begin
            if (wr_hit(sfr_addr_i, ADDR_LAT_LOW)) begin
                lat_clr[7:2] = ~sfr_wdata_i[7:2];
            end
            if (wr_hit(sfr_addr_i, ADDR_LAT_HIGH)) begin
                lat_clr[15:8] = ~sfr_wdata_i;
            end
            if (wr_hit(sfr_addr_i, ADDR_LAT_UPPER)) begin
                lat_clr[23:16] = ~sfr_wdata_i;
            end
            if (wr_hit(sfr_addr_i, ADDR_EN_LOW)) begin
                nxt_st.en[7:4] = sfr_wdata_i[7:4];
                nxt_st.ime     = sfr_wdata_i[IME_BIT];
            end
            if (wr_hit(sfr_addr_i, ADDR_EN_HIGH)) begin
                nxt_st.en[15:8] = sfr_wdata_i;
            end
            if (wr_hit(sfr_addr_i, ADDR_EN_UPPER)) begin
                nxt_st.en[23:16] = sfr_wdata_i;
            end
        end

        unique case (st_ff.state)
            ILS_IDLE: begin
                if (return_from_maskable_i || return_from_nonmaskable_i) begin
                    nxt_st.ime = stacked_ime_i;
                    if (return_from_nonmaskable_i) begin
                        nxt_st.nmi_svc = 1'b0;
                    end
                end else if (take_any) begin
                    nxt_st.state     = ILS_RUN;
                    nxt_st.busy      = 1'b1;
                    nxt_st.cnt       = 5'h00;
                    nxt_st.saved_ime = st_ff.ime;
                    nxt_st.ime       = 1'b0;
                    nxt_st.src       = take_nmi_insn ? SRC_SOFT : pk_idx;
                    nxt_st.nmi_svc   = take_nmi_insn || (pk_idx < SRC_FIRST_MASK);
                end
            end
            ILS_RUN: begin
                nxt_st.cnt = st_ff.cnt + 5'h01;
                if (st_ff.cnt == CNT_LAT_CLR) begin
                    for (int i = 2; i < SRC_COUNT; i++) begin
                        if (st_ff.src == 5'(i)) begin
                            lat_clr[i] = 1'b1;
                        end
                    end
                end
                if (st_ff.cnt == CNT_PUSH_PSW) begin
                    nxt_st.push_v = 1'b1;
                    nxt_st.push_d = psw_i;
                    nxt_st.push_d[PSW_IME_BIT] = st_ff.saved_ime;
                end
                if (st_ff.cnt == CNT_PUSH_PCH) begin
                    nxt_st.push_v = 1'b1;
                    nxt_st.push_d = pc_i[15:8];
                end
                if (st_ff.cnt == CNT_PUSH_PCL) begin
                    nxt_st.push_v = 1'b1;
                    nxt_st.push_d = pc_i[7:0];
                    nxt_st.sp_dec = 1'b1;
                end
                if (st_ff.cnt == CNT_VEC_LOAD) begin
                    nxt_st.vec_ld = 1'b1;
                end
                if (st_ff.cnt == CNT_LAST) begin
                    nxt_st.exec  = 1'b1;
                    nxt_st.busy  = 1'b0;
                    nxt_st.state = ILS_IDLE;
                end
            end
        endcase

        nxt_st.lat = (st_ff.lat & ~lat_clr) | src_req_i;
    end

    // ==========================================================
    // Registers.
    // reset clears.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    assign sfr_rdata_o   = st_ff.rdata;
    assign acc_busy_o    = st_ff.busy;
    assign acc_src_o     = st_ff.src;
    assign push_valid_o  = st_ff.push_v;
    assign push_data_o   = st_ff.push_d;
    assign sp_dec3_o     = st_ff.sp_dec;
    assign vector_load_o = st_ff.vec_ld;
    assign exec_start_o  = st_ff.exec;
    assign ime_o         = st_ff.ime;
    assign nmi_service_o = st_ff.nmi_svc;

    // ==========================================================
    // Checks.
    latch_set_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ce_i && src_req_i[5] |=> st_ff.lat[5])
        else $error("Request did not set its latch.");

    accept_clear_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ce_i && st_ff.busy && st_ff.cnt == CNT_LAT_CLR && st_ff.src == 5'h05 && !src_req_i[5]
        |=> !st_ff.lat[5])
        else $error("Accepted latch was not cleared.");

    sw_clear_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ce_i && sfr_wr_i && sfr_addr_i == ADDR_LAT_LOW && !sfr_wdata_i[7] && !src_req_i[7]
        |=> !st_ff.lat[7])
        else $error("Write of zero did not clear latch.");

    latch_hold_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ce_i && st_ff.lat[9] && !(sfr_wr_i && sfr_addr_i == ADDR_LAT_HIGH)
        && !(st_ff.busy && st_ff.src == 5'h09) |=> st_ff.lat[9])
        else $error("Held request was lost.");

    read_back_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ce_i && sfr_rd_i && sfr_addr_i == ADDR_LAT_HIGH |=> sfr_rdata_o == $past(st_ff.lat[15:8]))
        else $error("Latch readback mismatch.");

    nmi_take_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ce_i && !st_ff.busy && insn_end_i && st_ff.lat[2] && !return_from_maskable_i && !return_from_nonmaskable_i
        |=> acc_busy_o && !ime_o)
        else $error("Non-maskable request not accepted.");

    mask_block_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ce_i && !st_ff.busy && !st_ff.ime && !swi_i && !undef_i && st_ff.lat[3:2] == 2'b00
        |=> !acc_busy_o)
        else $error("Maskable request taken while disabled.");

    seq_end_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ce_i && st_ff.busy && st_ff.cnt == CNT_LAST |=> exec_start_o && !acc_busy_o)
        else $error("Acceptance did not end on time.");

    last_push_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ce_i && st_ff.busy && st_ff.cnt == CNT_PUSH_PCL |=> push_valid_o && sp_dec3_o)
        else $error("Low program-counter push missing.");

    ime_restore_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ce_i && !st_ff.busy && return_from_maskable_i |=> ime_o == $past(stacked_ime_i))
        else $error("Master enable not restored on return.");

    trap_first_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ce_i && !st_ff.busy && insn_end_i && st_ff.lat[2] && !swi_i && !undef_i && !return_from_maskable_i && !return_from_nonmaskable_i
        |=> acc_src_o == 5'h02)
        else $error("Lowest latched source was not chosen first.");

    nest_block_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ce_i && st_ff.busy && !(sfr_wr_i && sfr_addr_i == ADDR_EN_LOW)
        |=> !ime_o)
        else $error("Master enable rose during acceptance.");

    en_block_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ce_i && !st_ff.busy && insn_end_i && !swi_i && !undef_i && st_ff.lat[3:2] == 2'b00
        && (st_ff.lat[23:4] & st_ff.en) == 20'h00000 |=> !acc_busy_o)
        else $error("Source taken without its enable bit.");

    reset_clear_a: assert property (
        @(posedge sys_clk_i)
        !rst_n_i ##1 !rst_n_i |-> st_ff.lat == '0 && st_ff.en == '0 && !st_ff.ime)
        else $error("Reset left a latch or enable set.");

endmodule

/* File: bench/ils_cpu_model.sv */
// CPU core model that ends instructions, stacks pushes and issues returns.
`timescale 1ns/10ps
module ils_cpu_model
    import ils_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Test control.
    input  wire logic        ret_req_i,
    // Block side.
    input  wire logic        acc_busy_i,
    input  wire logic        push_valid_i,
    input  wire logic [7:0]  push_data_i,
    input  wire logic        nmi_service_i,
    output logic             insn_end_o,
    output logic             return_from_maskable_o,
    output logic             return_from_nonmaskable_o,
    output logic             stacked_ime_o,
    output logic      [7:0]  psw_o,
    output logic      [15:0] pc_o,
    output logic      [23:0] stk_o
);
    logic [1:0] step;
    logic       ret_pend;

    // ==========================================================
    // Instructions last four clocks and stand still while the block is busy.
    assign psw_o         = 8'ha4;
    assign pc_o          = 16'h5a3c;
    assign stacked_ime_o = stk_o[16+PSW_IME_BIT];
    assign insn_end_o    = (step == 2'h3) && !acc_busy_i;
    assign return_from_maskable_o        = insn_end_o && ret_pend && !nmi_service_i;
    assign return_from_nonmaskable_o        = insn_end_o && ret_pend && nmi_service_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step     <= 2'h0;
            ret_pend <= 1'b0;
            stk_o    <= 24'h000000;
        end else begin
            step <= acc_busy_i ? 2'h0 : step + 2'h1;
            if (ret_req_i) begin
                ret_pend <= 1'b1;
            end else if (insn_end_o) begin
                ret_pend <= 1'b0;
            end
            if (push_valid_i) begin
                stk_o <= {stk_o[15:0], push_data_i};
            end
        end
    end
endmodule

/* File: bench/ils_seq_test.sv */
// Self-checking bench for the interrupt latch and enable sequencer.
`timescale 1ns/10ps
module ils_seq_test;
    import ils_pkg::*;

    logic        sys_clk_i   = 1'b0;
    logic        rst_n_i     = 1'b0;
    logic [7:0]  sfr_addr_i  = 8'h00;
    logic [7:0]  sfr_wdata_i = 8'h00;
    logic        sfr_wr_i    = 1'b0;
    logic        sfr_rd_i    = 1'b0;
    logic        swi_i       = 1'b0;
    logic        undef_i     = 1'b0;
    logic        ret_req     = 1'b0;
    logic        ce          = 1'b1;
    logic [23:2] src_req_i   = '0;
    logic [7:0]  sfr_rdata_o, program_status_word, push_data_o;
    logic [15:0] pc;
    logic [23:0] stk;
    logic [4:0]  acc_src_o;
    logic        insn_end, return_from_maskable_o, return_from_nonmaskable_o, stk_ime, acc_busy_o, push_valid_o;
    logic        sp_dec3_o, vector_load_o, exec_start_o, ime_o, nmi_service_o;
    int          mismatches  = 0;
    int          checked     = 0;

    ils_seq u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .src_req_i(src_req_i), .swi_i(swi_i), .undef_i(undef_i), .insn_end_i(insn_end), .return_from_maskable_i(return_from_maskable_o),
        .return_from_nonmaskable_i(return_from_nonmaskable_o), .stacked_ime_i(stk_ime), .psw_i(program_status_word), .pc_i(pc), .acc_busy_o(acc_busy_o),
        .acc_src_o(acc_src_o), .push_valid_o(push_valid_o), .push_data_o(push_data_o),
        .sp_dec3_o(sp_dec3_o), .vector_load_o(vector_load_o), .exec_start_o(exec_start_o),
        .ime_o(ime_o), .nmi_service_o(nmi_service_o));

    ils_cpu_model u_cpu (.clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ret_req_i(ret_req), .acc_busy_i(acc_busy_o),
        .push_valid_i(push_valid_o), .push_data_i(push_data_o), .nmi_service_i(nmi_service_o),
        .insn_end_o(insn_end), .return_from_maskable_o(return_from_maskable_o), .return_from_nonmaskable_o(return_from_nonmaskable_o), .stacked_ime_o(stk_ime), .psw_o(program_status_word),
        .pc_o(pc), .stk_o(stk));

    always #50 sys_clk_i = ~sys_clk_i;

    // ==========================================================
    // Shared helpers.
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #10;
    endtask

    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_i  = a;
        sfr_wdata_i = d;
        sfr_wr_i    = 1'b1;
        tick(1);
        sfr_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr_i = a;
        sfr_rd_i   = 1'b1;
        tick(1);
        sfr_rd_i = 1'b0;
        check(sfr_rdata_o, exp, "register read");
    endtask

    task automatic pulse(input logic [23:2] m);
        src_req_i = m;
        tick(1);
        src_req_i = '0;
    endtask

    task automatic idle(input int n);
        int k;
        k = 0;
        repeat (n) begin
            k += acc_busy_o;
            tick(1);
        end
        check(k, 0, "no acceptance");
    endtask

    // Waits for acceptance and follows the whole sequence.
    task automatic serve(input logic [4:0] s, input logic pime);
        int n;
        int sp;
        n  = 0;
        sp = 0;
        while (acc_busy_o !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
        swi_i   = 1'b0;
        undef_i = 1'b0;
        check(n <= WORST_LAT_CLKS, 1, "latency");
        check(acc_src_o, s, "source");
        check(ime_o, 1'b0, "ime cleared");
        n = 0;
        while (acc_busy_o === 1'b1 && n < 40) begin
            sp += 2 * sp_dec3_o + vector_load_o + 4 * exec_start_o;
            tick(1);
            n++;
        end
        sp += 4 * exec_start_o;
        check(n, ACC_MC * MC_CLKS, "busy length");
        check(sp, 7, "stack and vector");
        check(stk, {program_status_word[7:1], pime, pc}, "stacked bytes");
    endtask

    task automatic ret(input logic exp_ime);
        int n;
        n       = 0;
        ret_req = 1'b1;
        tick(1);
        ret_req = 1'b0;
        while (!(return_from_maskable_o | return_from_nonmaskable_o) && n < 8) begin
            tick(1);
            n++;
        end
        check(n < 8, 1, "return issued");
        tick(1);
        check(ime_o, exp_ime, "ime restored");
        check(nmi_service_o, 1'b0, "service ended");
    endtask

    // ==========================================================
    // Scenarios.
    task automatic t_reset;
        logic [7:0] a [7] = '{8'h2c, 8'h2e, 8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h30};
        wr(8'h2c, 8'hff);
        pulse(22'h3fffff);
        tick(5);
        check(acc_src_o, 5'h02, "trap taken first");
        rst_n_i = 1'b0;
        tick(2);
        rst_n_i = 1'b1;
        tick(1);
        foreach (a[i]) begin
            rd(a[i], 8'h00);
            tick(1);
        end
        check(ime_o, 1'b0, "ime reset");
        check(acc_busy_o, 1'b0, "busy reset");
    endtask

    task automatic t_regs;
        wr(8'h2c, 8'hff);
        rd(8'h2c, 8'hff);
        wr(8'h3b, 8'hff);
        rd(8'h3b, 8'hff);
        wr(8'h3a, 8'hf0);
        rd(8'h3a, 8'hf0);
        pulse(22'h80);
        rd(8'h3d, 8'h02);
        wr(8'h3d, 8'hff);
        rd(8'h3d, 8'h02);
        wr(8'h3d, 8'hfd);
        rd(8'h3d, 8'h00);
        ce = 1'b0;
        pulse(22'h80);
        ce = 1'b1;
        rd(8'h3d, 8'h00);
        pulse(22'h20);
        wr(8'h3c, 8'h0c);
        rd(8'h3c, 8'h00);
        pulse(22'h4);
        rd(8'h3c, 8'h10);
        idle(60);
        rd(8'h3c, 8'h10);
        wr(8'h3a, 8'hf1);
        rd(8'h3a, 8'hf1);
        serve(5'h04, 1'b1);
        rd(8'h3c, 8'h00);
        pulse(22'h8);
        idle(40);
        ret(1'b1);
        serve(5'h05, 1'b1);
        ret(1'b1);
    endtask

    task automatic t_nmi;
        wr(8'h3a, 8'hf0);
        pulse(22'h2);
        serve(5'h03, 1'b0);
        check(nmi_service_o, 1'b1, "nmi service");
        ret(1'b0);
        swi_i = 1'b1;
        serve(SRC_SOFT, 1'b0);
        ret(1'b0);
        undef_i = 1'b1;
        serve(SRC_SOFT, 1'b0);
        check(nmi_service_o, 1'b1, "undef service");
        ret(1'b0);
    endtask

    task automatic t_prio;
        pulse(22'h420);
        wr(8'h3a, 8'hf1);
        serve(5'h07, 1'b1);
        wr(8'h3a, 8'h70);
        rd(8'h3a, 8'h70);
        wr(8'h3a, 8'h71);
        serve(5'h0c, 1'b1);
        ret(1'b1);
        ret(1'b1);
    endtask

    task automatic conclude;
        if (mismatches == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        tick(6);
        rst_n_i = 1'b1;
        tick(1);
        t_reset;
        t_regs;
        t_nmi;
        t_prio;
        conclude;
    end

    initial begin
        #(3000 * 100);
        mismatches++;
        conclude;
    end
endmodule
